// file: verilog/serial_io_pkg.sv
// Package for the three-wire serial interface: register map, field layout,
// reset values, carrier structs and states. Assumes a 32-bit APB register bus.
package serial_io_pkg;

    localparam int           APB_DW          = 32;
    localparam int           APB_AW          = 32;
    localparam int           DATA_W          = 8;
    localparam int           BITS_PER_XFER   = 8;
    localparam int           CNT_W           = 4;

    // Register indices; byte address is four times the index
    localparam logic [31:0]  IDX_PORT_DIR    = 32'h0000FF21;
    localparam logic [31:0]  IDX_MODE        = 32'h0000FF80;
    localparam logic [31:0]  IDX_CLK_PHASE   = 32'h0000FF81;
    localparam logic [31:0]  IDX_TX_BUF      = 32'h0000FF82;
    localparam logic [31:0]  IDX_SHIFT       = 32'h0000FF83;
    localparam logic [31:0]  IDX_STATUS      = 32'h0000FF84;
    localparam logic [31:0]  ADDR_PORT_DIR   = IDX_PORT_DIR << 2;
    localparam logic [31:0]  ADDR_MODE       = IDX_MODE << 2;
    localparam logic [31:0]  ADDR_CLK_PHASE  = IDX_CLK_PHASE << 2;
    localparam logic [31:0]  ADDR_TX_BUF     = IDX_TX_BUF << 2;
    localparam logic [31:0]  ADDR_SHIFT      = IDX_SHIFT << 2;
    localparam logic [31:0]  ADDR_STATUS     = IDX_STATUS << 2;

    // Mode register fields
    localparam int           MODE_EN_BIT     = 7;
    localparam int           MODE_TRMD_BIT   = 6;
    localparam int           MODE_DIR_BIT    = 4;
    localparam int           MODE_BUSY_BIT   = 0;
    // Clock and phase register fields
    localparam int           CP_CKP_BIT      = 4;
    localparam int           CP_DAP_BIT      = 3;
    localparam int           CP_CKS_LSB      = 0;
    localparam logic [2:0]   CKS_SLAVE       = 3'h7;
    // Status register fields
    localparam int           STAT_DONE_BIT   = 0;
    // Port pins used by the serial lines
    localparam int           PIN_SCK         = 5;
    localparam int           PIN_SO          = 7;

    localparam logic [7:0]   PORT_DIR_RST    = 8'hFF;
    localparam logic [7:0]   TX_BUF_RST      = 8'h00;
    localparam logic [7:0]   SHIFT_RST       = 8'h00;
    // Master divider: fx / 2^(cks + DIV_EXP_BASE), half period in cycles
    localparam int           DIV_EXP_BASE    = 2;
    localparam int           DIV_CNT_W       = 8;

    typedef struct packed {
        logic en;
        logic trmd;
        logic dir;
    } mode_t;

    typedef struct packed {
        logic       ckp;
        logic       dap;
        logic [2:0] cks;
    } clk_cfg_t;

    localparam mode_t        MODE_RST        = '0;
    localparam clk_cfg_t     CLK_CFG_RST     = '0;

    typedef enum logic {ST_IDLE, ST_BUSY} xfer_state_t;

endpackage

// file: verilog/sio_sync2.sv
// Two-flop synchroniser, one chain per bit. Inputs come from pins.
// Assumes the single system clock and active-low asynchronous reset.
module sio_sync2
    import serial_io_pkg::*;
#(
    parameter int W = 2
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_b,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_q;

    for (genvar g = 0; g < W; g++) begin : g_bit
        always_ff @(posedge i_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
                meta_q[g] <= 1'b0;
                o_sync[g] <= 1'b0;
            end else begin
                meta_q[g] <= i_async[g];
                o_sync[g] <= meta_q[g];
            end
        end
    end
endmodule

// file: verilog/sio_clk_gen.sv
// Master serial clock generator: toggles every half period while running,
// otherwise rests at the idle level chosen by the polarity bit.
// Assumes the caller stops it at the end of a frame.
module sio_clk_gen
    import serial_io_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    input  wire logic       i_run,
    input  wire logic       i_ckp,
    input  wire logic [2:0] i_cks,
    output logic            o_sck
);
    logic [DIV_CNT_W-1:0] div_q;
    logic [DIV_CNT_W-1:0] half_m1;

    // Half period of fx/2^(cks+2) is 2^(cks+1) cycles
    assign half_m1 = DIV_CNT_W'((1 << (int'(i_cks) + DIV_EXP_BASE - 1)) - 1);

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            div_q <= '0;
            o_sck <= 1'b1;
        end else if (!i_run) begin
            div_q <= '0;
            o_sck <= ~i_ckp;
        end else if (div_q == half_m1) begin
            div_q <= '0;
            o_sck <= ~o_sck;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end
endmodule

// file: verilog/serial_io_top.sv
// Three-wire clocked serial interface with APB register access.
// Assumes an APB master on I_SYS_CLK and pins from an outside partner.
// Behaviour
// - Enable low clears busy flag and shift register
// - Receive-only holds output low; else full duplex
// - Eight bits per transfer, MSB or LSB first
// - Buffer write starts transfer in transmit mode
// - Shift register read starts receive-only transfer
// - Busy flag sets when transfer starts
// - After eight bits: done flag set, busy clear
// - Busy flag bit ignores software writes
// - Codes 0-6: master, clock fx/2^2..2^8
// - Code 7: slave, follow external clock
// - Polarity and phase pick type; reset type 1
// - Phase 0: output lead edge, sample trail
// - Phase 0: later bits on lead edges
// - Phase 1: first bit at start, sample lead
// - Output holds last bit after transfer
// - Disabled output level per mode and phase
// - Reset clears mode and clock registers
// - Direction bits: 0 output, reset all ones
//
// Implementation choice: the APB interface to the registers.
module serial_io_top
    import serial_io_pkg::*;
(
    input  wire logic              I_SYS_CLK,
    input  wire logic              I_RST_B,
    input  wire logic              I_PSEL,
    input  wire logic              I_PENABLE,
    input  wire logic              I_PWRITE,
    input  wire logic [APB_AW-1:0] I_PADDR,
    input  wire logic [APB_DW-1:0] I_PWDATA,
    output logic      [APB_DW-1:0] O_PRDATA,
    output logic                   O_PREADY,
    output logic                   O_PSLVERR,
    input  wire logic              I_SCK,
    output logic                   O_SCK,
    output logic                   O_SCK_OE,
    input  wire logic              I_SI,
    output logic                   O_SO,
    output logic                   O_SO_OE,
    output logic      [7:0]        O_PORT_DIR
);
    mode_t              mode_q;
    clk_cfg_t           cfg_q;
    logic [7:0]         port_dir_q;
    logic [7:0]         tx_buf_q;
    logic [7:0]         shift_q;
    logic [CNT_W-1:0]   bit_cnt_q;
    xfer_state_t        state_q;
    logic               done_q;
    logic               so_latch_q;
    logic               so_out_q;
    logic               sck_prev_q;
    logic [1:0]         pins_sync;
    logic               gen_sck;
    logic               busy;
    logic               master;
    logic               setup_acc;
    logic               commit;
    logic               wr_commit;
    logic               rd_commit;
    logic               start_tx;
    logic               start_rx;
    logic               start;
    logic               sck_now;
    logic               ph_now;
    logic               ph_prev;
    logic               lead_edge;
    logic               trail_edge;
    logic               sample_edge;
    logic               out_edge;
    logic               last_trail;
    logic               si_bit;
    logic               mapped;
    logic [7:0]         rd_byte;
    logic [7:0]         shift_next;

    sio_sync2 #(.W(2)) u_sync (
        .i_clk   (I_SYS_CLK),
        .i_rst_b (I_RST_B),
        .i_async ({I_SI, I_SCK}),
        .o_sync  (pins_sync)
    );

    sio_clk_gen u_clk_gen (
        .i_clk   (I_SYS_CLK),
        .i_rst_b (I_RST_B),
        .i_run   (busy && master),
        .i_ckp   (cfg_q.ckp),
        .i_cks   (cfg_q.cks),
        .o_sck   (gen_sck)
    );

    assign busy   = (state_q == ST_BUSY);
    assign master = (cfg_q.cks != CKS_SLAVE);
    assign si_bit = pins_sync[1];

    // APB: first access cycle prepares data, second cycle completes
    assign setup_acc = I_PSEL && I_PENABLE && !O_PREADY;
    assign commit    = I_PSEL && I_PENABLE && O_PREADY;
    assign wr_commit = commit && I_PWRITE;
    assign rd_commit = commit && !I_PWRITE;

    assign start_tx = wr_commit && (I_PADDR == ADDR_TX_BUF)
                      && mode_q.en && mode_q.trmd && !busy;
    assign start_rx = rd_commit && (I_PADDR == ADDR_SHIFT)
                      && mode_q.en && !mode_q.trmd && !busy;
    assign start    = start_tx || start_rx;

    // Serial clock phase normalised so that 1 is the idle level
    assign sck_now    = master ? gen_sck : pins_sync[0];
    assign ph_now     = sck_now ^ cfg_q.ckp;
    assign ph_prev    = sck_prev_q ^ cfg_q.ckp;
    assign lead_edge  = busy && ph_prev && !ph_now;
    assign trail_edge = busy && !ph_prev && ph_now;
    assign sample_edge = cfg_q.dap ? lead_edge : trail_edge;
    assign out_edge    = cfg_q.dap ? trail_edge : lead_edge;
    assign last_trail  = trail_edge && (cfg_q.dap ? (bit_cnt_q == CNT_W'(BITS_PER_XFER))
                                                  : (bit_cnt_q == CNT_W'(BITS_PER_XFER - 1)));

    // Shift toward the first-bit end chosen by the order bit
    assign shift_next = mode_q.dir ? {si_bit, shift_q[7:1]}
                                   : {shift_q[6:0], si_bit};

    always_comb begin
        mapped  = 1'b1;
        rd_byte = 8'h00;
        unique case (I_PADDR)
            ADDR_PORT_DIR:  rd_byte = port_dir_q;
            ADDR_MODE: begin
                rd_byte[MODE_EN_BIT]   = mode_q.en;
                rd_byte[MODE_TRMD_BIT] = mode_q.trmd;
                rd_byte[MODE_DIR_BIT]  = mode_q.dir;
                rd_byte[MODE_BUSY_BIT] = busy;
            end
            ADDR_CLK_PHASE: begin
                rd_byte[CP_CKP_BIT]              = cfg_q.ckp;
                rd_byte[CP_DAP_BIT]              = cfg_q.dap;
                rd_byte[CP_CKS_LSB +: 3]         = cfg_q.cks;
            end
            ADDR_TX_BUF:    rd_byte = tx_buf_q;
            ADDR_SHIFT:     rd_byte = shift_q;
            ADDR_STATUS:    rd_byte[STAT_DONE_BIT] = done_q;
            default:        mapped = 1'b0;
        endcase
    end

    // APB answer
    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_PREADY  <= 1'b0;
            O_PRDATA  <= '0;
            O_PSLVERR <= 1'b0;
        end else begin
            O_PREADY  <= setup_acc;
            O_PSLVERR <= setup_acc && !mapped;
            if (setup_acc) begin
                O_PRDATA <= {{(APB_DW - 8){1'b0}}, rd_byte};
            end
        end
    end

    // Control registers
    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            mode_q     <= MODE_RST;
            cfg_q      <= CLK_CFG_RST;
            port_dir_q <= PORT_DIR_RST;
            tx_buf_q   <= TX_BUF_RST;
        end else if (wr_commit) begin
            unique case (I_PADDR)
                ADDR_PORT_DIR:  port_dir_q <= I_PWDATA[7:0];
                ADDR_MODE: begin
                    // Busy bit position is not stored
                    mode_q.en   <= I_PWDATA[MODE_EN_BIT];
                    mode_q.trmd <= I_PWDATA[MODE_TRMD_BIT];
                    mode_q.dir  <= I_PWDATA[MODE_DIR_BIT];
                end
                ADDR_CLK_PHASE: begin
                    cfg_q.ckp <= I_PWDATA[CP_CKP_BIT];
                    cfg_q.dap <= I_PWDATA[CP_DAP_BIT];
                    cfg_q.cks <= I_PWDATA[CP_CKS_LSB +: 3];
                end
                ADDR_TX_BUF:    tx_buf_q <= I_PWDATA[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            sck_prev_q <= 1'b1;
        end else begin
            sck_prev_q <= sck_now;
        end
    end

    // Transfer engine: state, bit count and shift register
    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            state_q   <= ST_IDLE;
            bit_cnt_q <= '0;
            shift_q   <= SHIFT_RST;
        end else if (!mode_q.en) begin
            state_q   <= ST_IDLE;
            bit_cnt_q <= '0;
            shift_q   <= SHIFT_RST;
        end else if (start) begin
            state_q   <= ST_BUSY;
            bit_cnt_q <= '0;
            if (start_tx) begin
                shift_q <= I_PWDATA[7:0];
            end
        end else begin
            if (sample_edge) begin
                shift_q   <= shift_next;
                bit_cnt_q <= bit_cnt_q + 1'b1;
            end
            if (last_trail) begin
                state_q <= ST_IDLE;
            end
        end
    end

    // Sticky done flag, write one to clear; a new completion wins
    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            done_q <= 1'b0;
        end else if (mode_q.en && last_trail) begin
            done_q <= 1'b1;
        end else if (wr_commit && (I_PADDR == ADDR_STATUS) && I_PWDATA[STAT_DONE_BIT]) begin
            done_q <= 1'b0;
        end
    end

    // Output latch for the serial data line
    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            so_latch_q <= 1'b0;
        end else if (!mode_q.en) begin
            so_latch_q <= 1'b0;
        end else if (start && cfg_q.dap) begin
            // First bit at the access strobe; rx-only start is masked at the pin
            so_latch_q <= mode_q.dir ? tx_buf_q[0] : tx_buf_q[7];
            if (start_tx) begin
                so_latch_q <= mode_q.dir ? I_PWDATA[0] : I_PWDATA[7];
            end
        end else if (out_edge && !(cfg_q.dap && bit_cnt_q == CNT_W'(BITS_PER_XFER))) begin
            so_latch_q <= mode_q.dir ? shift_q[0] : shift_q[7];
        end
    end

    // Pin drivers; the latch keeps the last bit between transfers
    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            so_out_q <= 1'b0;
            O_SCK_OE <= 1'b0;
            O_SO_OE  <= 1'b0;
        end else begin
            if (!mode_q.trmd) begin
                so_out_q <= 1'b0;
            end else if (!mode_q.en && cfg_q.dap) begin
                so_out_q <= mode_q.dir ? tx_buf_q[0] : tx_buf_q[7];
            end else begin
                so_out_q <= so_latch_q;
            end
            O_SCK_OE <= mode_q.en && master && !port_dir_q[PIN_SCK];
            O_SO_OE  <= mode_q.trmd && !port_dir_q[PIN_SO];
        end
    end

    assign O_SO       = so_out_q;
    assign O_SCK      = gen_sck;
    assign O_PORT_DIR = port_dir_q;

    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RST_B);

    disable_clears_a: assert property (!mode_q.en |=> !busy && shift_q == 8'h00)
        else $error("disable did not clear transfer state");
    rxonly_low_a: assert property (!mode_q.trmd |=> !O_SO)
        else $error("receive-only output not low");
    bit_limit_a: assert property (bit_cnt_q <= CNT_W'(BITS_PER_XFER))
        else $error("bit count exceeded eight");
    write_start_a: assert property (start_tx |=> busy && bit_cnt_q == '0)
        else $error("buffer write did not start transfer");
    read_start_a: assert property (start_rx |=> busy && !$past(busy))
        else $error("shift read did not start reception");
    done_end_a: assert property ($fell(busy) && $past(mode_q.en) |-> done_q)
        else $error("completion without done flag");
    busy_ro_a: assert property (wr_commit && I_PADDR == ADDR_MODE && !busy
                                |=> !busy)
        else $error("mode write changed busy flag");
    slave_no_drive_a: assert property (cfg_q.cks == CKS_SLAVE |=> !O_SCK_OE)
        else $error("slave mode drives clock");
    idle_hold_a: assert property (!busy && !start && mode_q.en && $stable(mode_q)
                                  |=> $stable(so_latch_q))
        else $error("output latch moved while idle");
    disabled_so_a: assert property (!mode_q.en && mode_q.trmd && cfg_q.dap
                                    |=> O_SO == $past(mode_q.dir ? tx_buf_q[0] : tx_buf_q[7]))
        else $error("disabled output not buffer end bit");


    // Data line, clock pin, busy and done flag, counter and direction register checks
    start_latch_a: assert property (start_tx && cfg_q.dap
        |=> so_latch_q == (mode_q.dir ? $past(I_PWDATA[0]) : $past(I_PWDATA[7])))
        else $error("phase 1 first bit not latched at start");
    disabled_latch_a: assert property (!mode_q.en
        |=> !so_latch_q)
        else $error("output latch not low while disabled");
    so_follow_a: assert property (mode_q.en && mode_q.trmd
        |=> O_SO == $past(so_latch_q))
        else $error("serial out does not follow latch");
    clk_idle_a: assert property (!(busy && master)
        |=> O_SCK == !$past(cfg_q.ckp))
        else $error("serial clock not at idle level");
    done_busy_a: assert property (last_trail && mode_q.en
        |=> done_q && !busy)
        else $error("last edge did not end transfer");
    busy_hold_a: assert property (busy && mode_q.en && !last_trail
        |=> busy)
        else $error("busy flag dropped mid transfer");
    idle_stays_a: assert property (!busy && !start
        |=> !busy)
        else $error("transfer began without a start");
    count_step_a: assert property (sample_edge && mode_q.en
        |=> bit_cnt_q == CNT_W'($past(bit_cnt_q) + 1'b1))
        else $error("bit count did not step on sample edge");
    rx_no_drive_a: assert property (!mode_q.trmd
        |=> !O_SO_OE)
        else $error("receive-only mode enables data output");
    master_drive_a: assert property (mode_q.en && master && !port_dir_q[PIN_SCK]
        |=> O_SCK_OE)
        else $error("master clock pin not enabled");
    dir_reg_a: assert property (wr_commit && I_PADDR == ADDR_PORT_DIR
        |=> O_PORT_DIR == $past(I_PWDATA[7:0]))
        else $error("direction write not applied");

    tx_done_c: cover property (busy && mode_q.trmd ##1 !busy && done_q);
    rx_done_c: cover property (busy && !mode_q.trmd ##1 !busy && done_q);
    slave_xfer_c: cover property (busy && !master && last_trail);
    phase1_c: cover property (busy && cfg_q.dap && last_trail);
    rx_start_c: cover property (start_rx);
endmodule

// file: test/sio_peer_model.sv
// Behavioural peripheral on the far side of the three-wire link.
// Assumes the bench resolves the clock wire and passes polarity and phase.
module sio_peer_model (
    input  wire logic       i_clk,
    input  wire logic       i_sck,
    input  wire logic       i_so,
    input  wire logic       i_ckp,
    input  wire logic       i_dap,
    output logic            o_si,
    output logic            o_sck,
    output logic            o_sck_oe,
    output logic      [7:0] o_rx
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] tx_q  = 8'h00;
    int         idx   = 8;
    int         nsamp = 8;
    initial begin
        o_si     = 1'b0;
        o_sck    = 1'b1;
        o_sck_oe = 1'b0;
        o_rx     = 8'h00;
    end
    task automatic arm(input logic [7:0] b);
        // Off the clock edge, after the clock pin enable has settled
        repeat (2) @(negedge i_clk);
        tx_q  = b;
        o_rx  = 8'h00;
        nsamp = 0;
        idx   = 0;
        if (i_dap) begin
            o_si = b[7];
            idx  = 1;
        end
    endtask
    // Released data line changes every cycle so a stale value is never read
    always @(posedge i_clk) begin
        if (nsamp >= 8) o_si <= ~o_si;
    end
    // Follows whichever party drives the clock wire
    always @(i_sck) begin
        if (nsamp < 8 && ((i_sck == i_ckp) == i_dap)) begin
            o_rx  = {o_rx[6:0], i_so};
            nsamp = nsamp + 1;
        end else if (idx < 8) begin
            o_si = tx_q[7-idx];
            idx  = idx + 1;
        end
    end
    // Slave-mode clock: eight periods of 48 ns, still outside the frame
    task automatic run_clk();
        o_sck    = ~i_ckp;
        o_sck_oe = 1'b1;
        repeat (16) begin
            #24;
            o_sck = ~o_sck;
        end
        #24;
        o_sck_oe = 1'b0;
    endtask
endmodule

// file: test/testbench.sv
// Self-checking bench: APB register tasks and serial transfers against a peer.
// Assumes the peer model and a pull-up on the clock and output wires.
module testbench
    import serial_io_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk     = 1'b0;
    logic        rst_b   = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [31:0] paddr   = '0;
    logic [31:0] pwdata  = '0;
    logic [31:0] prdata;
    logic        pready, pslverr, o_sck, sck_oe, so, so_oe;
    logic [7:0]  port_dir, pk_rx;
    logic        pk_si, pk_sck, pk_oe;
    logic        ckp = 1'b0;
    logic        dap = 1'b0;
    logic [31:0] r;
    logic        e;
    int          h;
    int          bad_count = 0;
    int          n_tests   = 0;
    wire         sck_w = sck_oe ? o_sck : (pk_oe ? pk_sck : 1'b1);
    wire         so_w  = so_oe ? so : 1'b1;

    always #2.5 clk = ~clk;

    serial_io_top serial_io_top_inst (
        .I_SYS_CLK(clk), .I_RST_B(rst_b), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr), .I_SCK(sck_w), .O_SCK(o_sck),
        .O_SCK_OE(sck_oe), .I_SI(pk_si), .O_SO(so), .O_SO_OE(so_oe), .O_PORT_DIR(port_dir));
    sio_peer_model sio_peer_model_inst (
        .i_clk(clk), .i_sck(sck_w), .i_so(so_w), .i_ckp(ckp), .i_dap(dap),
        .o_si(pk_si), .o_sck(pk_sck), .o_sck_oe(pk_oe), .o_rx(pk_rx));

    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            bad_count++;
            report_and_stop();
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        logic [31:0] x;
        logic        y;
        apb(1'b1, a, {24'h0, d}, x, y);
    endtask
    task automatic rd(input string what, input logic [31:0] a, input logic [7:0] exp);
        logic [31:0] x;
        logic        y;
        apb(1'b0, a, 32'h0, x, y);
        chk(what, x, {24'h0, exp});
    endtask
    // Polls the done flag, then clears it; control registers untouched
    task automatic wait_done();
        int n;
        n = 0;
        do begin
            apb(1'b0, ADDR_STATUS, 32'h0, r, e);
            n++;
        end while (r[0] !== 1'b1 && n < 1000);
        if (n >= 1000) begin
            bad_count++;
            report_and_stop();
        end
        wr(ADDR_STATUS, 8'h01);
    endtask
    task automatic so_chk(input logic exp);
        repeat (3) @(posedge clk);
        chk("serial out", {31'h0, so}, {31'h0, exp});
    endtask
    // Cycles between the first two toggles of the master clock
    task automatic half_period(output int hp);
        int   n;
        logic s;
        n = 0;
        s = o_sck;
        while (o_sck === s && n < 2000) begin
            @(posedge clk);
            n++;
        end
        s  = o_sck;
        hp = 0;
        while (o_sck === s && hp < 2000) begin
            @(posedge clk);
            hp++;
        end
    endtask
    function automatic logic [7:0] rev(input logic [7:0] b);
        for (int i = 0; i < 8; i++) rev[i] = b[7-i];
    endfunction

    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        rd("port dir", ADDR_PORT_DIR, 8'hFF);
        rd("mode", ADDR_MODE, 8'h00);
        rd("clock phase", ADDR_CLK_PHASE, 8'h00);
        apb(1'b0, 32'h0, 32'h0, r, e);
        chk("unmapped err", {31'h0, e}, 32'h1);
        wr(ADDR_PORT_DIR, 8'h5F);
        rd("port dir", ADDR_PORT_DIR, 8'h5F);
        chk("port pins", {24'h0, port_dir}, 32'h5F);
        wr(ADDR_MODE, 8'h01);
        rd("busy write", ADDR_MODE, 8'h00);
        for (int k = 0; k < 7; k++) begin
            wr(ADDR_MODE, 8'h40);
            wr(ADDR_CLK_PHASE, 8'(k));
            wr(ADDR_MODE, 8'hC0);
            sio_peer_model_inst.arm(8'h5A);
            wr(ADDR_TX_BUF, 8'h97);
            half_period(h);
            chk("half period", h, 32'd1 << (k + 1));
            if (k == 0) rd("busy", ADDR_MODE, 8'hC1);
            wait_done();
            rd("idle", ADDR_MODE, 8'hC0);
            if (k >= 2) begin
                chk("peer rx", {24'h0, pk_rx}, 32'h97);
                rd("rx byte", ADDR_SHIFT, 8'h5A);
                chk("last bit", {31'h0, so}, 32'h1);
            end
        end
        rd("done cleared", ADDR_STATUS, 8'h00);
        wr(ADDR_MODE, 8'h40);
        ckp = 1'b1;
        dap = 1'b1;
        wr(ADDR_CLK_PHASE, 8'h1A);
        wr(ADDR_MODE, 8'hD0);
        sio_peer_model_inst.arm(8'h3C);
        wr(ADDR_TX_BUF, 8'hC5);
        wait_done();
        chk("peer rx lsb", {24'h0, pk_rx}, {24'h0, rev(8'hC5)});
        rd("rx lsb", ADDR_SHIFT, rev(8'h3C));
        chk("last bit lsb", {31'h0, so}, 32'h1);
        wr(ADDR_MODE, 8'h40);
        wr(ADDR_TX_BUF, 8'h80);
        so_chk(1'b1);
        wr(ADDR_MODE, 8'h50);
        so_chk(1'b0);
        wr(ADDR_TX_BUF, 8'h01);
        so_chk(1'b1);
        wr(ADDR_CLK_PHASE, 8'h02);
        so_chk(1'b0);
        wr(ADDR_MODE, 8'h00);
        so_chk(1'b0);
        ckp = 1'b0;
        dap = 1'b0;
        wr(ADDR_CLK_PHASE, 8'h07);
        wr(ADDR_MODE, 8'h80);
        sio_peer_model_inst.arm(8'hB4);
        apb(1'b0, ADDR_SHIFT, 32'h0, r, e);
        sio_peer_model_inst.run_clk();
        wait_done();
        chk("rx only out", {31'h0, so}, 32'h0);
        rd("slave rx", ADDR_SHIFT, 8'hB4);
        rd("rx restart", ADDR_MODE, 8'h81);
        wr(ADDR_MODE, 8'h00);
        rd("busy cleared", ADDR_MODE, 8'h00);
        rd("shift cleared", ADDR_SHIFT, 8'h00);
        report_and_stop();
    end
endmodule
